// ### design/ode_defs.svh
// Field positions, codes and reset values of the octal double-rate enable descriptor
`ifndef ODE_DEFS_SVH
`define ODE_DEFS_SVH
`define ODE_BIT_AVAIL    31
`define ODE_BIT_POL      30
`define ODE_BIT_RSVD     29
`define ODE_BIT_ADDRD    28
`define ODE_BIT_BYTE1    27
`define ODE_POS_HI       26
`define ODE_POS_LO       24
`define ODE_LADDR_HI     23
`define ODE_LADDR_LO     16
`define ODE_BIT_M8D      23
`define ODE_BIT_M8S      22
`define ODE_BIT_M4SDD    21
`define ODE_BIT_M4SSS    20
`define ODE_DUMMY_HI     19
`define ODE_DUMMY_LO     16
`define ODE_RDOP_HI      15
`define ODE_RDOP_LO      8
`define ODE_WROP_HI      7
`define ODE_WROP_LO      0
`define ODE_OP_NONE      8'h00
`define ODE_RSVD_VAL     1'h0
`define ODE_DESC_IDX     8'h15
`define ODE_DUMMY_MAX    15
`define ODE_SINGLE_DUMMY 4'h0
`define ODE_MEM_RESET    8'h00
`endif

// ### design/ode_pkg.sv
// Types shared by the octal double-rate enable block
package ode_pkg;
	// Lane and rate mode of an incoming command
	typedef enum logic [2:0] {
		ODE_MODE_1S1S1S,
		ODE_MODE_8D8D8D,
		ODE_MODE_8S8S8S,
		ODE_MODE_4S4D4D,
		ODE_MODE_4S4S4S,
		ODE_MODE_OTHER
	} ode_mode_type;
endpackage

// ### design/ode_cfg_mem.sv
// Byte-wide configuration register map with registered read data
`timescale 1ns/1ns
`include "ode_defs.svh"
module ode_cfg_mem #(
	parameter int AW = 8
) (
	input  wire logic          ref_clk,
	input  wire logic          arst_n,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [7:0]    wrData,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [7:0]    rdData_r
);
	localparam int DEPTH = 1 << AW;
	logic [7:0] cell_r [DEPTH];

	// One resettable byte per entry so every read is defined after reset
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_cell
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					cell_r[gi] <= `ODE_MEM_RESET;
				end else if (wrEn && (wrAddr == AW'(gi))) begin
					cell_r[gi] <= wrData;
				end
			end
		end
	endgenerate

	// Read port is one cycle late; a write in the same cycle is not forwarded
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_r <= `ODE_MEM_RESET;
		end else begin
			rdData_r <= cell_r[rdAddr];
		end
	end
endmodule

// ### design/ode_desc_top.sv
// Octal double-rate enable descriptor word and the volatile enable register it describes
`timescale 1ns/1ns
`include "ode_defs.svh"
module ode_desc_top #(
	parameter bit       AVAILABLE  = 1'b1,
	parameter bit       POL_INV    = 1'b0,
	parameter bit       ADDRESSED  = 1'b0,
	parameter bit       ADDR_BYTE1 = 1'b0,
	parameter int       ADDR_BITS  = 24,
	parameter int       BIT_POS    = 3,
	parameter bit [7:0] LOCAL_ADDR = 8'h00,
	parameter bit       MODE_8D    = 1'b1,
	parameter bit       MODE_8S    = 1'b0,
	parameter bit       MODE_4SDD  = 1'b0,
	parameter bit       MODE_4SSS  = 1'b0,
	parameter int       DUMMY      = 8,
	parameter bit [7:0] RD_OP      = 8'h65,
	parameter bit [7:0] WR_OP      = 8'h71
) (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic                 paramRdReq,
	input  wire logic [7:0]           paramRdIdx,
	output logic                      paramRdValid_r,
	output logic      [31:0]          paramRdData_r,
	input  wire logic                 cmdValid,
	input  wire logic [7:0]           cmdOpcode,
	input  wire logic                 cmdHasAddr,
	input  wire logic [31:0]          cmdAddr,
	input  wire ode_pkg::ode_mode_type cmdMode,
	input  wire logic [3:0]           cmdDummy,
	input  wire logic [7:0]           cmdWrData,
	output logic                      cmdDone_r,
	output logic                      cmdRejected_r,
	output logic                      cmdRdValid_r,
	output logic      [7:0]           cmdRdData_r,
	output logic                      octalDdrEnable_r
);
	// Refuse configurations the decode cannot serve, at elaboration
	if (ADDR_BYTE1 && ADDR_BITS == 8) begin : g_bad_byte1
		$error("second address byte needs 24 or 32 bit address");
	end
	if (ADDR_BITS != 8 && ADDR_BITS != 24 && ADDR_BITS != 32) begin : g_bad_width
		$error("address width must be 8, 24 or 32");
	end
	if (BIT_POS < 0 || BIT_POS > 7) begin : g_bad_pos
		$error("enable bit position must be 0 to 7");
	end
	if (DUMMY < 0 || DUMMY > `ODE_DUMMY_MAX) begin : g_bad_dummy
		$error("dummy count must be 0 to 15");
	end

	localparam logic [3:0] DUMMY_C   = 4'(DUMMY);
	localparam logic [2:0] POS_C     = 3'(BIT_POS);
	// Enable bit starts at its disabling value
	localparam logic [7:0] LOC_RESET = 8'(POL_INV) << BIT_POS;

	// Descriptor word assembly
	logic [31:0] descWord;
	always_comb begin
		descWord = 32'h0000_0000;
		descWord[`ODE_BIT_AVAIL] = AVAILABLE;
		descWord[`ODE_BIT_POL] = POL_INV;
		descWord[`ODE_BIT_RSVD] = `ODE_RSVD_VAL;
		descWord[`ODE_BIT_ADDRD] = ADDRESSED;
		descWord[`ODE_BIT_BYTE1] = ADDR_BYTE1;
		descWord[`ODE_POS_HI:`ODE_POS_LO] = POS_C;
		if (ADDRESSED) begin
			descWord[`ODE_LADDR_HI:`ODE_LADDR_LO] = LOCAL_ADDR;
		end else begin
			descWord[`ODE_BIT_M8D] = MODE_8D;
			descWord[`ODE_BIT_M8S] = MODE_8S;
			descWord[`ODE_BIT_M4SDD] = MODE_4SDD;
			descWord[`ODE_BIT_M4SSS] = MODE_4SSS;
			descWord[`ODE_DUMMY_HI:`ODE_DUMMY_LO] = DUMMY_C;
		end
		descWord[`ODE_RDOP_HI:`ODE_RDOP_LO] = RD_OP;
		descWord[`ODE_WROP_HI:`ODE_WROP_LO] = WR_OP;
	end

	// Parameter read answers one cycle later; other word indices read as zero
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			paramRdValid_r <= 1'b0;
			paramRdData_r  <= 32'h0000_0000;
		end else begin
			paramRdValid_r <= paramRdReq;
			if (paramRdReq) begin
				paramRdData_r <= (paramRdIdx == `ODE_DESC_IDX) ? descWord : 32'h0000_0000;
			end
		end
	end

	// Command decode
	logic [7:0] addrByte;
	logic [7:0] regAddr;
	logic       isRead;
	logic       isWrite;
	logic       modeOk;
	logic       styleOk;
	logic       accept;
	always_comb begin
		addrByte = ADDR_BYTE1 ? cmdAddr[15:8] : cmdAddr[7:0];
		regAddr  = ADDRESSED ? addrByte : LOCAL_ADDR;
		// A 00h opcode never matches, so an absent command is refused
		isRead   = (RD_OP != `ODE_OP_NONE) && (cmdOpcode == RD_OP);
		isWrite  = (WR_OP != `ODE_OP_NONE) && (cmdOpcode == WR_OP);
		styleOk  = (cmdHasAddr == ADDRESSED);
		// Unflagged modes are refused here; the host must not assume so
		case (cmdMode)
			ode_pkg::ODE_MODE_1S1S1S: modeOk = (cmdDummy == `ODE_SINGLE_DUMMY);
			ode_pkg::ODE_MODE_8D8D8D: modeOk = MODE_8D && (cmdDummy == DUMMY_C);
			ode_pkg::ODE_MODE_8S8S8S: modeOk = MODE_8S && (cmdDummy == DUMMY_C);
			ode_pkg::ODE_MODE_4S4D4D: modeOk = MODE_4SDD && (cmdDummy == DUMMY_C);
			ode_pkg::ODE_MODE_4S4S4S: modeOk = MODE_4SSS && (cmdDummy == DUMMY_C);
			default:                  modeOk = 1'b0;
		endcase
		// Addressed access carries no published dummy count, so mode is not checked
		if (ADDRESSED) begin
			modeOk = 1'b1;
		end
		accept = cmdValid && AVAILABLE && styleOk && modeOk && (isRead || isWrite);
	end

	// Register holding the enable bit; other map entries live in the memory
	logic [7:0] localReg_r;
	logic       hitLocal;
	assign hitLocal = (regAddr == LOCAL_ADDR);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			localReg_r <= LOC_RESET;
		end else if (accept && isWrite && hitLocal) begin
			localReg_r <= cmdWrData;
		end
	end

	logic [7:0] memRdData;
	ode_cfg_mem #(
		.AW(8)
	) i_ode_cfg_mem (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.wrEn     (accept && isWrite && !hitLocal),
		.wrAddr   (regAddr),
		.wrData   (cmdWrData),
		.rdAddr   (regAddr),
		.rdData_r (memRdData)
	);

	// First stage waits for the memory's registered read
	logic s1Valid_r;
	logic s1Accept_r;
	logic s1Read_r;
	logic s1Local_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1Valid_r  <= 1'b0;
			s1Accept_r <= 1'b0;
			s1Read_r   <= 1'b0;
			s1Local_r  <= 1'b0;
		end else begin
			s1Valid_r  <= cmdValid;
			s1Accept_r <= accept;
			s1Read_r   <= accept && isRead;
			s1Local_r  <= hitLocal;
		end
	end

	// Second stage drives the answer; local byte is read live, after any write
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmdDone_r     <= 1'b0;
			cmdRejected_r <= 1'b0;
			cmdRdValid_r  <= 1'b0;
			cmdRdData_r   <= 8'h00;
		end else begin
			cmdDone_r     <= s1Valid_r && s1Accept_r;
			cmdRejected_r <= s1Valid_r && !s1Accept_r;
			cmdRdValid_r  <= s1Read_r;
			if (s1Read_r) begin
				cmdRdData_r <= s1Local_r ? localReg_r : memRdData;
			end
		end
	end

	// Mode enable follows the stored bit through the polarity
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			octalDdrEnable_r <= 1'b0;
		end else begin
			octalDdrEnable_r <= AVAILABLE && (localReg_r[POS_C] != POL_INV);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	property p_avail;
		paramRdReq && paramRdIdx == `ODE_DESC_IDX |=> paramRdData_r[31] == AVAILABLE;
	endproperty
	a_avail: assert property (p_avail) else $error("availability bit wrong");
	property p_pol;
		paramRdReq && paramRdIdx == `ODE_DESC_IDX |=> paramRdData_r[30] == POL_INV;
	endproperty
	a_pol: assert property (p_pol) else $error("polarity bit wrong");
	property p_rsvd;
		paramRdValid_r |-> !paramRdData_r[29];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit not zero");
	property p_style;
		cmdValid && cmdHasAddr != ADDRESSED |-> ##2 cmdRejected_r && !cmdDone_r;
	endproperty
	a_style: assert property (p_style) else $error("wrong access style not refused");
	property p_addr;
		accept && isWrite && ADDRESSED &&
			(ADDR_BYTE1 ? cmdAddr[15:8] : cmdAddr[7:0]) == LOCAL_ADDR
			|=> localReg_r == $past(cmdWrData);
	endproperty
	a_addr: assert property (p_addr) else $error("local address byte misplaced");
	property p_pos;
		paramRdReq && paramRdIdx == `ODE_DESC_IDX |=> paramRdData_r[26:24] == POS_C;
	endproperty
	a_pos: assert property (p_pos) else $error("bit position field wrong");
	property p_field;
		paramRdReq && paramRdIdx == `ODE_DESC_IDX |=> paramRdData_r[23:16] == (ADDRESSED ?
			LOCAL_ADDR : {MODE_8D, MODE_8S, MODE_4SDD, MODE_4SSS, DUMMY_C});
	endproperty
	a_field: assert property (p_field) else $error("address or mode field wrong");
	property p_single;
		cmdValid && !ADDRESSED && cmdMode == ode_pkg::ODE_MODE_1S1S1S && cmdDummy != 4'h0
			|-> ##2 cmdRejected_r;
	endproperty
	a_single: assert property (p_single) else $error("single-lane dummy not refused");
	property p_ops;
		paramRdReq && paramRdIdx == `ODE_DESC_IDX |=> paramRdData_r[15:0] == {RD_OP, WR_OP};
	endproperty
	a_ops: assert property (p_ops) else $error("opcode fields wrong");
	property p_nullop;
		cmdValid && cmdOpcode == `ODE_OP_NONE |-> ##2 cmdRejected_r;
	endproperty
	a_nullop: assert property (p_nullop) else $error("00h opcode accepted");
	property p_enable;
		accept && isWrite && hitLocal |=> ##1 octalDdrEnable_r == (AVAILABLE &&
			($past(cmdWrData, 2) >> BIT_POS) % 2 != POL_INV);
	endproperty
	a_enable: assert property (p_enable) else $error("enable does not follow write");

	c_desc:  cover property (paramRdReq && paramRdIdx == `ODE_DESC_IDX ##1 paramRdValid_r);
	c_write: cover property (accept && isWrite ##2 cmdDone_r);
	c_read:  cover property (accept && isRead ##2 cmdRdValid_r);
	c_rej:   cover property (cmdValid && !accept ##2 cmdRejected_r);
endmodule

// ### test/ode_host_model.sv
// Host controller model that decodes the descriptor and issues commands
`timescale 1ns/1ns
module ode_host_model (
	input  wire logic                  ref_clk,
	output logic                       paramRdReq,
	output logic [7:0]                 paramRdIdx,
	input  wire logic                  paramRdValid_r,
	input  wire logic [31:0]           paramRdData_r,
	output logic                       cmdValid,
	output logic [7:0]                 cmdOpcode,
	output logic                       cmdHasAddr,
	output logic [31:0]                cmdAddr,
	output ode_pkg::ode_mode_type      cmdMode,
	output logic [3:0]                 cmdDummy,
	output logic [7:0]                 cmdWrData,
	input  wire logic                  cmdDone_r,
	input  wire logic                  cmdRejected_r,
	input  wire logic                  cmdRdValid_r,
	input  wire logic [7:0]            cmdRdData_r
);
	// Quiet at time zero
	initial begin
		{paramRdReq, paramRdIdx, cmdValid, cmdOpcode, cmdHasAddr} = '0;
		{cmdAddr, cmdDummy, cmdWrData} = '0;
		cmdMode = ode_pkg::ODE_MODE_OTHER;
	end

	// One parameter word; answer read just after the take edge, while valid stands
	task automatic param_read(input logic [7:0] idx, output logic v, output logic [31:0] d);
		@(posedge ref_clk);
		#1;
		paramRdReq = 1'b1;
		paramRdIdx = idx;
		@(posedge ref_clk);
		#1;
		paramRdReq = 1'b0;
		paramRdIdx = ~idx; // Released index never repeats the old value
		v = paramRdValid_r;
		d = paramRdData_r;
	endtask

	// One command; result {done, refused, read valid} read while its pulse stands
	task automatic cmd(input logic [7:0] op, input logic ha, input logic [31:0] a,
		input ode_pkg::ode_mode_type m, input logic [3:0] dm, input logic [7:0] wd,
		output logic [2:0] res, output logic [7:0] rd);
		@(posedge ref_clk);
		#1;
		cmdValid = 1'b1;
		cmdOpcode = op;
		cmdHasAddr = ha;
		cmdAddr = a;
		cmdMode = m;
		cmdDummy = dm;
		cmdWrData = wd;
		@(posedge ref_clk);
		#1;
		cmdValid = 1'b0;
		cmdOpcode = ~op;
		cmdAddr = ~a;
		cmdDummy = ~dm;
		cmdWrData = ~wd;
		@(posedge ref_clk);
		#1;
		res = {cmdDone_r, cmdRejected_r, cmdRdValid_r};
		rd = cmdRdData_r;
	endtask

	// Enable sequence driven only by what the descriptor publishes
	task automatic enable_octal(output logic ok);
		logic                  v;
		logic [31:0]           w;
		logic [31:0]           a;
		logic [2:0]            res;
		logic [7:0]            b;
		logic [3:0]            dm;
		ode_pkg::ode_mode_type m;
		ok = 1'b0;
		param_read(8'h15, v, w);
		if (!w[31]) return;
		// A cleared flag is not taken as a ban: fall back to single lane
		m = w[23] ? ode_pkg::ODE_MODE_8D8D8D : w[22] ? ode_pkg::ODE_MODE_8S8S8S :
			w[21] ? ode_pkg::ODE_MODE_4S4D4D : w[20] ? ode_pkg::ODE_MODE_4S4S4S :
			ode_pkg::ODE_MODE_1S1S1S;
		dm = (m == ode_pkg::ODE_MODE_1S1S1S) ? 4'h0 : w[19:16];
		a = w[27] ? {16'h0000, w[23:16], 8'h00} : {24'h000000, w[23:16]};
		cmd(w[15:8], w[28], a, m, dm, 8'h00, res, b);
		b[w[26:24]] = ~w[30];
		cmd(w[7:0], w[28], a, m, dm, b, res, b);
		ok = res[2];
	endtask
endmodule

// ### test/ode_desc_top_test.sv
// Testbench for the octal double-rate enable descriptor block
`timescale 1ns/1ns
module ode_desc_top_test;
	localparam bit          POL  = 1'b1;
	localparam logic [2:0]  POS  = 3'h3;
	localparam logic [7:0]  RDOP = 8'h65;
	localparam logic [7:0]  WROP = 8'h71;
	localparam logic [31:0] DESC = {3'h6, 2'h0, POS, 8'h88, RDOP, WROP};
	logic                  ref_clk;
	logic                  arst_n;
	logic                  rq, vd, cv, ha, dn, rj, rv, en, v, ok;
	logic [7:0]            ix, op, wd, rd, b;
	logic [31:0]           pd, ca, d;
	logic                  av, adn, arj, arv, aen;
	logic [7:0]            ard;
	logic [31:0]           ad;
	logic [3:0]            dm;
	logic [2:0]            res;
	ode_pkg::ode_mode_type md;
	int                    mismatches = 0;
	int                    comparisons = 0;

	ode_desc_top #(.POL_INV(POL), .BIT_POS(3), .DUMMY(8), .RD_OP(RDOP), .WR_OP(WROP)) i_ode_desc_top (
		.ref_clk(ref_clk), .arst_n(arst_n), .paramRdReq(rq), .paramRdIdx(ix),
		.paramRdValid_r(vd), .paramRdData_r(pd), .cmdValid(cv), .cmdOpcode(op),
		.cmdHasAddr(ha), .cmdAddr(ca), .cmdMode(md), .cmdDummy(dm), .cmdWrData(wd),
		.cmdDone_r(dn), .cmdRejected_r(rj), .cmdRdValid_r(rv), .cmdRdData_r(rd),
		.octalDdrEnable_r(en));

	// Second configuration: addressed access, register address in address byte 1
	ode_desc_top #(.ADDRESSED(1'b1), .ADDR_BYTE1(1'b1), .LOCAL_ADDR(8'h5A), .RD_OP(RDOP),
		.WR_OP(WROP)) i_ode_desc_top_adr (
		.ref_clk(ref_clk), .arst_n(arst_n), .paramRdReq(rq), .paramRdIdx(ix),
		.paramRdValid_r(av), .paramRdData_r(ad), .cmdValid(cv), .cmdOpcode(op),
		.cmdHasAddr(ha), .cmdAddr(ca), .cmdMode(md), .cmdDummy(dm), .cmdWrData(wd),
		.cmdDone_r(adn), .cmdRejected_r(arj), .cmdRdValid_r(arv), .cmdRdData_r(ard),
		.octalDdrEnable_r(aen));

	ode_host_model i_ode_host_model (
		.ref_clk(ref_clk), .paramRdReq(rq), .paramRdIdx(ix), .paramRdValid_r(vd),
		.paramRdData_r(pd), .cmdValid(cv), .cmdOpcode(op), .cmdHasAddr(ha), .cmdAddr(ca),
		.cmdMode(md), .cmdDummy(dm), .cmdWrData(wd), .cmdDone_r(dn), .cmdRejected_r(rj),
		.cmdRdValid_r(rv), .cmdRdData_r(rd));

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A direct command that must be taken or refused
	task automatic try(input logic [7:0] o, input logic h, input ode_pkg::ode_mode_type m,
		input logic [3:0] n, input logic refuse);
		i_ode_host_model.cmd(o, h, 32'h0, m, n, 8'h00, res, b);
		check({29'h0, res}, refuse ? 32'h2 : 32'h5);
	endtask

	task automatic give_verdict();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Tests need well under 400 cycles
	initial begin
		#(40 * 2000);
		mismatches++;
		give_verdict();
	end

	initial begin
		arst_n = 1'b0;
		repeat (16) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		i_ode_host_model.param_read(8'h15, v, d);
		check({v, d}, {1'b1, DESC});
		check({av, ad}, {1'b1, 5'h13, POS, 8'h5A, RDOP, WROP});
		i_ode_host_model.param_read(8'h14, v, d);
		check({v, d}, {1'b1, 32'h0});
		$display("descriptor test done");
		// Reset value of the enable register reads back disabled
		i_ode_host_model.cmd(RDOP, 1'b0, 32'h0, ode_pkg::ODE_MODE_8D8D8D, 4'h8, 8'h00, res, b);
		check({res, b, en}, {3'h5, 8'h08, 1'b0});
		try(RDOP, 1'b0, ode_pkg::ODE_MODE_1S1S1S, 4'h0, 1'b0);
		try(RDOP, 1'b0, ode_pkg::ODE_MODE_1S1S1S, 4'h8, 1'b1);
		try(RDOP, 1'b0, ode_pkg::ODE_MODE_8D8D8D, 4'h7, 1'b1);
		try(RDOP, 1'b0, ode_pkg::ODE_MODE_8S8S8S, 4'h8, 1'b1);
		try(RDOP, 1'b0, ode_pkg::ODE_MODE_4S4D4D, 4'h8, 1'b1);
		try(RDOP, 1'b0, ode_pkg::ODE_MODE_4S4S4S, 4'h8, 1'b1);
		try(RDOP, 1'b0, ode_pkg::ODE_MODE_OTHER, 4'h8, 1'b1);
		try(RDOP, 1'b1, ode_pkg::ODE_MODE_8D8D8D, 4'h8, 1'b1);
		try(8'h00, 1'b0, ode_pkg::ODE_MODE_8D8D8D, 4'h8, 1'b1);
		$display("command mode test done");
		// Inverted polarity: clearing the bit turns the mode on
		i_ode_host_model.enable_octal(ok);
		@(posedge ref_clk);
		#1;
		check({ok, en}, 2'h3);
		i_ode_host_model.cmd(RDOP, 1'b0, 32'h0, ode_pkg::ODE_MODE_8D8D8D, 4'h8, 8'h00, res, b);
		check({res, b}, {3'h5, 8'h00});
		$display("enable test done");
		// Addressed access: the direct instance refuses, the addressed one takes byte 1
		i_ode_host_model.cmd(WROP, 1'b1, 32'h0000_5A00, ode_pkg::ODE_MODE_OTHER, 4'h0,
			8'h08, res, b);
		check({res, adn, arj, aen}, {3'h2, 3'h5});
		// Byte 0 names the enable register, so a wrong byte would clear the mode
		i_ode_host_model.cmd(WROP, 1'b1, 32'h0000_3C5A, ode_pkg::ODE_MODE_OTHER, 4'h0,
			8'hA5, res, b);
		i_ode_host_model.cmd(RDOP, 1'b1, 32'h0000_3C00, ode_pkg::ODE_MODE_OTHER, 4'h0,
			8'h00, res, b);
		check({arv, ard, aen}, {1'b1, 8'hA5, 1'b1});
		i_ode_host_model.cmd(RDOP, 1'b1, 32'hFFFF_5A77, ode_pkg::ODE_MODE_OTHER, 4'h0,
			8'h00, res, b);
		check({arv, ard}, {1'b1, 8'h08});
		$display("addressed access test done");
		give_verdict();
	end
endmodule
